/* hdl/tmr_ctrl.v */
// 16-bit timer control/status slice with an AXI4-Lite register port
// How it works
// - pin-1 enable only routes the waveform to compare pin 1; compare keeps running.
// - pin-2 enable only routes channel 2 level to compare pin 2.
// - one-pulse mode: capture-1 edge starts one pulse, length from compare-1.
// - PWM mode: pulse length from compare-1, period from compare-2.
// - clock select 00 /4, 01 /2, 10 /8, 11 external pin.
// - without an external pin, external select halts the counter.
// - capture-2 edge select: 0 falling, 1 rising.
// - external clock edge bit: 0 falling, 1 rising.
// - capture-1 flag on capture-1 or PWM period end; cleared by status read then low byte.
// - compare-1 flag on counter match outside PWM mode; cleared by status read then compare-1 low byte.
// - overflow flag on FFFF to 0000 wrap; cleared by status read then counter low byte.
// - alternate counter low byte never clears the overflow flag.
// - capture-2 flag on capture-2 event; cleared by status read then its low byte.
// - compare-2 flag on counter match outside PWM mode; cleared by status read then compare-2 low byte.
// - timer disable freezes prescaler and counter and shuts both compare pins.
// - all registers stay readable and writable while disabled.
// - capture-1 high byte is read-only, upper counter byte taken at capture 1.
// - capture-1 edge select: 0 falling, 1 rising; also one-pulse trigger polarity.
// - output level 2 drives compare pin 1 in the active phase of one-pulse and PWM.
// - writing the counter low byte resets the counter.
`timescale 1ns/1ps
`default_nettype none
`include "tmr_consts.vh"

module tmr_ctrl #(
    parameter EXT_CLK_PRESENT = 1
) (
    // clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // axi4-lite write address
    input  wire [5:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // axi4-lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // axi4-lite read address
    input  wire [5:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // axi4-lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // timer pins
    input  wire        capture_pin_1,
    input  wire        capture_pin_2,
    input  wire        ext_clock_pin,
    output reg         compare_pin_1,
    output reg         compare_pin_1_sel,
    output reg         compare_pin_2,
    output reg         compare_pin_2_sel
);

    // address decode shared by read and write paths
    function is_mapped;
        input [5:0] a;
        begin
            is_mapped = (a[1:0] == 2'b00) && (a <= `TMR_A_IC2L);
        end
    endfunction

    // edge of a synchronised pin, polarity chosen by sel
    function pin_edge;
        input stable;
        input now;
        input last;
        input sel;
        begin
            pin_edge = stable && (now != last) && (now == sel);
        end
    endfunction

    // registers
    reg  [7:0]  ctrl1_reg;
    reg  [7:0]  timer_control_second_reg;
    reg         timer_disable_reg;
    reg  [4:0]  flags_reg;
    reg  [4:0]  flags_next;
    reg  [4:0]  snap_reg;
    reg  [15:0] counter_reg;
    reg  [15:0] cmp1_reg;
    reg  [15:0] cmp2_reg;
    reg  [15:0] cap1_reg;
    reg  [15:0] cap2_reg;
    reg  [2:0]  presc_reg;
    reg         tick_d_reg;
    reg         pin1_level_reg;
    reg         pin2_level_reg;

    // synchronisers: [0] first stage, [1] second, [2] third
    reg  [2:0]  sync_c1_reg;
    reg  [2:0]  sync_c2_reg;
    reg  [2:0]  sync_ex_reg;
    reg         lvl_c1_reg;
    reg         lvl_c2_reg;
    reg         lvl_ex_reg;

    // axi holding registers
    reg  [5:0]  aw_addr_reg;
    reg         aw_held_reg;
    reg  [7:0]  w_data_reg;
    reg         w_en_reg;
    reg         w_held_reg;

    wire [1:0] clk_sel   = timer_control_second_reg[`TMR_C2_CSEL_HI:`TMR_C2_CSEL_LO];
    wire       pwm_on    = timer_control_second_reg[`TMR_C2_PWM];
    wire       one_pulse = timer_control_second_reg[`TMR_C2_ONEPLS];

    // change counts once second and third stage agree
    wire cap1_evt = pin_edge(sync_c1_reg[1] == sync_c1_reg[2], sync_c1_reg[2],
                             lvl_c1_reg, ctrl1_reg[`TMR_C1_CAPTURE1_EDGE_SELECT]);
    wire cap2_evt = pin_edge(sync_c2_reg[1] == sync_c2_reg[2], sync_c2_reg[2],
                             lvl_c2_reg, timer_control_second_reg[`TMR_C2_CAPTURE2_EDGE_SELECT]);
    wire ext_evt  = pin_edge(sync_ex_reg[1] == sync_ex_reg[2], sync_ex_reg[2],
                             lvl_ex_reg, timer_control_second_reg[`TMR_C2_EXT_CLOCK_EDGE]);

    // prescaler taps for /2, /4, /8
    reg  [2:0] presc_mask;
    always @* begin
        case (clk_sel)
            `TMR_CS_DIV2: presc_mask = 3'h1;
            `TMR_CS_DIV4: presc_mask = 3'h3;
            `TMR_CS_DIV8: presc_mask = 3'h7;
            default:      presc_mask = 3'h0;
        endcase
    end

    // external select on a part without the pin never ticks
    wire ext_ok = (EXT_CLK_PRESENT != 0);
    wire tick = !timer_disable_reg &&
                ((clk_sel == `TMR_CS_EXT) ? (ext_ok && ext_evt)
                                           : ((presc_reg & presc_mask) == presc_mask));

    // compare events seen one cycle after the counter moved
    wire match1 = tick_d_reg && (counter_reg == cmp1_reg);
    wire match2 = tick_d_reg && (counter_reg == cmp2_reg);
    wire ovf_evt = tick && (counter_reg == `TMR_CNT_MAX);
    // one-pulse trigger on the capture-1 active edge
    wire opm_start = one_pulse && !pwm_on && cap1_evt;
    // compare-2 match ends the PWM period
    wire pwm_wrap = pwm_on && match2;

    // bus write strobe and its target
    wire       do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
    wire       wr_hit   = do_write && w_en_reg && is_mapped(aw_addr_reg);
    wire       do_read  = s_axi_arvalid && s_axi_arready;
    wire       rd_hit   = do_read && is_mapped(s_axi_araddr);

    function acc;
        input [5:0] a;
        input       w;
        input [5:0] wa;
        input       r;
        input [5:0] ra;
        begin
            acc = (w && wa == a) || (r && ra == a);
        end
    endfunction

    wire acc_stat = acc(`TMR_A_STATUS, 1'b0, aw_addr_reg, rd_hit, s_axi_araddr);
    wire acc_ic1l = acc(`TMR_A_IC1L, wr_hit, aw_addr_reg, rd_hit, s_axi_araddr);
    wire acc_oc1l = acc(`TMR_A_OC1L, wr_hit, aw_addr_reg, rd_hit, s_axi_araddr);
    wire acc_oc2l = acc(`TMR_A_OC2L, wr_hit, aw_addr_reg, rd_hit, s_axi_araddr);
    wire acc_cntl = acc(`TMR_A_CNTL, wr_hit, aw_addr_reg, rd_hit, s_axi_araddr);
    wire acc_ic2l = acc(`TMR_A_IC2L, wr_hit, aw_addr_reg, rd_hit, s_axi_araddr);
    wire wr_cntl  = wr_hit && (aw_addr_reg == `TMR_A_CNTL);
    wire wr_acntl = wr_hit && (aw_addr_reg == `TMR_A_ACNTL);

    // flags: index 4 cap1, 3 cmp1, 2 ovf, 1 cap2, 0 cmp2
    // low-byte access clears a flag the status read saw
    // counter low byte clears overflow, alternate byte never
    wire [4:0] flag_acc = {acc_ic1l, acc_oc1l, acc_cntl, acc_ic2l, acc_oc2l};
    // capture-1 or PWM end; compare flags only outside PWM
    wire [4:0] flag_set = {cap1_evt || pwm_wrap, match1 && !pwm_on, ovf_evt, cap2_evt,
                           match2 && !pwm_on};

    // set wins over a clear in the same cycle
    always @* begin
        flags_next = (flags_reg & ~(flag_acc & snap_reg)) | flag_set;
    end

    // read data mux
    reg [7:0] rd_byte;
    always @* begin
        case (s_axi_araddr)
            `TMR_A_CTRL1:  rd_byte = ctrl1_reg;
            `TMR_A_CTRL2:  rd_byte = timer_control_second_reg;
            `TMR_A_STATUS: rd_byte = {flags_reg[4:1], flags_reg[0], timer_disable_reg, 2'b00};
            `TMR_A_IC1H:   rd_byte = cap1_reg[15:8];
            `TMR_A_IC1L:   rd_byte = cap1_reg[7:0];
            `TMR_A_OC1H:   rd_byte = cmp1_reg[15:8];
            `TMR_A_OC1L:   rd_byte = cmp1_reg[7:0];
            `TMR_A_OC2H:   rd_byte = cmp2_reg[15:8];
            `TMR_A_OC2L:   rd_byte = cmp2_reg[7:0];
            `TMR_A_CNTH:   rd_byte = counter_reg[15:8];
            `TMR_A_CNTL:   rd_byte = counter_reg[7:0];
            `TMR_A_ACNTH:  rd_byte = counter_reg[15:8];
            `TMR_A_ACNTL:  rd_byte = counter_reg[7:0];
            `TMR_A_IC2H:   rd_byte = cap2_reg[15:8];
            `TMR_A_IC2L:   rd_byte = cap2_reg[7:0];
            default:       rd_byte = 8'h00;
        endcase
    end

    // axi4-lite slave handshakes
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `TMR_RESP_OK;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= `TMR_RESP_OK;
            s_axi_rdata   <= 32'h0000_0000;
            aw_addr_reg   <= 6'h00;
            aw_held_reg   <= 1'b0;
            w_data_reg    <= 8'h00;
            w_en_reg      <= 1'b0;
            w_held_reg    <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_reg   <= s_axi_awaddr;
                aw_held_reg   <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_reg   <= s_axi_wdata[7:0];
                w_en_reg     <= s_axi_wstrb[0];
                w_held_reg   <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= is_mapped(aw_addr_reg) ? `TMR_RESP_OK : `TMR_RESP_ERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
            if (do_read) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= {24'h00_0000, rd_byte};
                s_axi_rresp   <= is_mapped(s_axi_araddr) ? `TMR_RESP_OK : `TMR_RESP_ERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // registers are written regardless of the disable bit
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl1_reg                <= `TMR_CTRL_RST;
            timer_control_second_reg <= `TMR_CTRL_RST;
            timer_disable_reg        <= 1'b0;
            cmp1_reg                 <= `TMR_CMP_RST;
            cmp2_reg                 <= `TMR_CMP_RST;
        end else if (wr_hit) begin
            case (aw_addr_reg)
                `TMR_A_CTRL1:  ctrl1_reg <= w_data_reg;
                `TMR_A_CTRL2:  timer_control_second_reg <= w_data_reg;
                `TMR_A_STATUS: timer_disable_reg <= w_data_reg[`TMR_ST_DIS];
                `TMR_A_OC1H:   cmp1_reg[15:8] <= w_data_reg;
                `TMR_A_OC1L:   cmp1_reg[7:0] <= w_data_reg;
                `TMR_A_OC2H:   cmp2_reg[15:8] <= w_data_reg;
                `TMR_A_OC2L:   cmp2_reg[7:0] <= w_data_reg;
                default:       ctrl1_reg <= ctrl1_reg;
            endcase
        end
    end

    // flags and the status-read snapshot
    always @(posedge aclk) begin
        if (!aresetn) begin
            flags_reg <= 5'h00;
            snap_reg  <= 5'h00;
        end else begin
            flags_reg <= flags_next;
            // a flag clears only if a status read saw it; one access uses it up
            snap_reg <= acc_stat ? flags_reg : (snap_reg & ~flag_acc);
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            sync_c1_reg <= 3'h0;
            sync_c2_reg <= 3'h0;
            sync_ex_reg <= 3'h0;
            lvl_c1_reg  <= 1'b0;
            lvl_c2_reg  <= 1'b0;
            lvl_ex_reg  <= 1'b0;
        end else begin
            sync_c1_reg <= {sync_c1_reg[1:0], capture_pin_1};
            sync_c2_reg <= {sync_c2_reg[1:0], capture_pin_2};
            sync_ex_reg <= {sync_ex_reg[1:0], ext_clock_pin};
            if (sync_c1_reg[1] == sync_c1_reg[2]) begin
                lvl_c1_reg <= sync_c1_reg[2];
            end
            if (sync_c2_reg[1] == sync_c2_reg[2]) begin
                lvl_c2_reg <= sync_c2_reg[2];
            end
            if (sync_ex_reg[1] == sync_ex_reg[2]) begin
                lvl_ex_reg <= sync_ex_reg[2];
            end
        end
    end

    // prescaler, counter and captures
    always @(posedge aclk) begin
        if (!aresetn) begin
            presc_reg   <= 3'h0;
            counter_reg <= `TMR_CNT_RST;
            tick_d_reg  <= 1'b0;
            cap1_reg    <= 16'h0000;
            cap2_reg    <= 16'h0000;
        end else begin
            if (!timer_disable_reg) begin
                presc_reg <= presc_reg + 3'h1;
            end
            tick_d_reg <= tick;
            // counter low byte write resets the count (alternate too)
            if (wr_cntl || wr_acntl || opm_start || pwm_wrap) begin
                counter_reg <= `TMR_CNT_RST;
            end else if (tick) begin
                counter_reg <= counter_reg + 16'h0001;
            end
            if (cap1_evt) begin
                cap1_reg <= counter_reg;
            end
            if (cap2_evt) begin
                cap2_reg <= counter_reg;
            end
        end
    end

    // waveform levels and pin drivers
    always @(posedge aclk) begin
        if (!aresetn) begin
            pin1_level_reg    <= 1'b0;
            pin2_level_reg    <= 1'b0;
            compare_pin_1     <= 1'b0;
            compare_pin_1_sel <= 1'b0;
            compare_pin_2     <= 1'b0;
            compare_pin_2_sel <= 1'b0;
        end else begin
            // level 2 during the active phase, level 1 after compare-1
            if (opm_start || (pwm_on && (pwm_wrap || match2))) begin
                pin1_level_reg <= ctrl1_reg[`TMR_C1_OUTPUT_LEVEL_2];
            end else if (match1) begin
                pin1_level_reg <= ctrl1_reg[`TMR_C1_OLVL1];
            end
            if (match2) begin
                pin2_level_reg <= ctrl1_reg[`TMR_C1_OUTPUT_LEVEL_2];
            end
            // pin-1 select only routes the level
            // disabled timer shuts both pins off
            compare_pin_1_sel <= timer_control_second_reg[`TMR_C2_PIN1EN] && !timer_disable_reg;
            compare_pin_1     <= timer_control_second_reg[`TMR_C2_PIN1EN] && !timer_disable_reg
                                 && pin1_level_reg;
            // pin-2 select only routes the level
            compare_pin_2_sel <= timer_control_second_reg[`TMR_C2_PIN2EN] && !timer_disable_reg;
            compare_pin_2     <= timer_control_second_reg[`TMR_C2_PIN2EN] && !timer_disable_reg
                                 && pin2_level_reg;
        end
    end

endmodule // tmr_ctrl

`default_nettype wire

/* hdl/tmr_consts.vh */
// register map, field positions and reset values for the timer control slice
`ifndef TMR_CONSTS_VH
`define TMR_CONSTS_VH

// byte addresses of the one-byte registers, one aligned word each
`define TMR_A_CTRL1    6'h00
`define TMR_A_CTRL2    6'h04
`define TMR_A_STATUS   6'h08
`define TMR_A_IC1H     6'h0C
`define TMR_A_IC1L     6'h10
`define TMR_A_OC1H     6'h14
`define TMR_A_OC1L     6'h18
`define TMR_A_OC2H     6'h1C
`define TMR_A_OC2L     6'h20
`define TMR_A_CNTH     6'h24
`define TMR_A_CNTL     6'h28
`define TMR_A_ACNTH    6'h2C
`define TMR_A_ACNTL    6'h30
`define TMR_A_IC2H     6'h34
`define TMR_A_IC2L     6'h38

// first control register fields
`define TMR_C1_OUTPUT_LEVEL_2   2
`define TMR_C1_CAPTURE1_EDGE_SELECT   1
`define TMR_C1_OLVL1   0

// second control register fields
`define TMR_C2_PIN1EN  7
`define TMR_C2_PIN2EN  6
`define TMR_C2_ONEPLS  5
`define TMR_C2_PWM     4
`define TMR_C2_CSEL_HI 3
`define TMR_C2_CSEL_LO 2
`define TMR_C2_CAPTURE2_EDGE_SELECT   1
`define TMR_C2_EXT_CLOCK_EDGE   0

// status register fields
`define TMR_ST_CAP1    7
`define TMR_ST_CMP1    6
`define TMR_ST_OVF     5
`define TMR_ST_CAP2    4
`define TMR_ST_CMP2    3
`define TMR_ST_DIS     2

// clock select codes
`define TMR_CS_DIV4    2'b00
`define TMR_CS_DIV2    2'b01
`define TMR_CS_DIV8    2'b10
`define TMR_CS_EXT     2'b11

// reset values and the counter maximum
`define TMR_CTRL_RST   8'h00
`define TMR_CNT_RST    16'h0000
`define TMR_CNT_MAX    16'hFFFF
`define TMR_CMP_RST    16'h0000

// bus responses
`define TMR_RESP_OK    2'b00
`define TMR_RESP_ERR   2'b10

`endif

/* verif/tmr_ctrl_asserts.sv */
// concurrent checks on the ports of the timer control slice
`timescale 1ns/1ps
`default_nettype none
module tmr_ctrl_asserts (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [5:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // compare pins
    input wire logic        compare_pin_1,
    input wire logic        compare_pin_1_sel,
    input wire logic        compare_pin_2,
    input wire logic        compare_pin_2_sel
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_pin1_gated: assert property (
        !compare_pin_1_sel |-> !compare_pin_1) else $error("pin 1 driven while free");
    chk_pin2_gated: assert property (
        !compare_pin_2_sel |-> !compare_pin_2) else $error("pin 2 driven while free");
    chk_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    chk_bresp_holds: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    chk_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data late");
    chk_rdata_holds: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    chk_byte_only: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000) else $error("upper read bits set");
    chk_status_rsvd: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr == 6'h08 |=> s_axi_rdata[1:0] == 2'b00)
        else $error("reserved status bits set");
    chk_unmapped_rd: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr == 6'h3C
        |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h00000000) else $error("unmapped read");
endmodule // tmr_ctrl_asserts

bind tmr_ctrl tmr_ctrl_asserts u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .compare_pin_1, .compare_pin_1_sel, .compare_pin_2, .compare_pin_2_sel);
`default_nettype wire

/* verif/tmr_ctrl_tb.sv */
// self-checking bench for the timer control slice
`timescale 1ns/1ps
`default_nettype none
`include "tmr_consts.vh"
module tmr_ctrl_tb;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [5:0]  s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    // capture 1 idles high so its falling edge is the event
    logic        capture_pin_1 = 1'b1, capture_pin_2 = 1'b0, ext_clock_pin = 1'b0;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    wire         compare_pin_1, compare_pin_1_sel, compare_pin_2, compare_pin_2_sel;
    int          errors = 0, num_checks = 0, cycles = 0, hi = 0;
    int          dv[3] = '{4, 2, 8};
    logic [31:0] rd;
    logic [1:0]  rs;

    always #12.5 aclk = ~aclk;

    tmr_ctrl dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .capture_pin_1, .capture_pin_2, .ext_clock_pin,
        .compare_pin_1, .compare_pin_1_sel, .compare_pin_2, .compare_pin_2_sel);

    task wrap_up;
        if (errors == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // a hung handshake ends here instead of spinning forever
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            wrap_up();
        end
    end

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task wr(input logic [5:0] a, input logic [7:0] d, input logic [1:0] er = `TMR_RESP_OK);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
    endtask

    task rdr(input logic [5:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        rd = s_axi_rdata;
        rs = s_axi_rresp;
    endtask

    task rdc(input logic [5:0] a, input logic [7:0] e, input logic [1:0] er = `TMR_RESP_OK);
        rdr(a);
        chk("rdata", rd, {24'h0, e});
        chk("rresp", {30'h0, rs}, {30'h0, er});
    endtask

    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rdc(`TMR_A_CTRL2, 8'h00);
        rdc(`TMR_A_STATUS, 8'h00);
        wr(`TMR_A_IC1H, 8'h5A);
        rdc(`TMR_A_IC1H, 8'h00);
        wr(6'h3C, 8'h11, `TMR_RESP_ERR);
        rdc(6'h3C, 8'h00, `TMR_RESP_ERR);
        wr(`TMR_A_CTRL2, 8'h84);
        repeat (3) @(posedge aclk);
        chk("pin1 sel", {31'h0, compare_pin_1_sel}, 32'h1);
        chk("pin2 sel", {31'h0, compare_pin_2_sel}, 32'h0);
        wr(`TMR_A_STATUS, 8'h04);
        repeat (3) @(posedge aclk);
        chk("pin1 sel off", {31'h0, compare_pin_1_sel}, 32'h0);
        rdc(`TMR_A_STATUS, 8'h04);
        wr(`TMR_A_CTRL2, 8'h04);
        rdc(`TMR_A_CTRL2, 8'h04);
        wr(`TMR_A_CNTL, 8'h00);
        repeat (40) @(posedge aclk);
        rdc(`TMR_A_CNTL, 8'h00);
        wr(`TMR_A_STATUS, 8'h00);
        // divider codes 00, 01, 10; bus overhead allows a small slack
        for (int i = 0; i < 3; i++) begin
            wr(`TMR_A_CTRL2, {4'h0, i[1:0], 2'b00});
            wr(`TMR_A_CNTL, 8'h00);
            repeat (160) @(posedge aclk);
            rdr(`TMR_A_CNTL);
            chk("rate", {31'h0, rd >= 160 / dv[i] - 2 && rd <= 160 / dv[i] + 3}, 32'h1);
        end
        for (int e = 0; e < 2; e++) begin
            wr(`TMR_A_CTRL2, {4'h0, 2'b11, 1'b0, e[0]});
            wr(`TMR_A_CNTL, 8'h00);
            ext_clock_pin <= 1'b1;
            repeat (10) @(posedge aclk);
            rdc(`TMR_A_CNTL, {7'h0, e[0]});
            ext_clock_pin <= 1'b0;
            repeat (10) @(posedge aclk);
            rdc(`TMR_A_CNTL, 8'h01);
        end
        wr(`TMR_A_OC1L, 8'h10);
        wr(`TMR_A_OC2L, 8'h20);
        wr(`TMR_A_CTRL2, 8'h04);
        wr(`TMR_A_CNTL, 8'h00);
        repeat (150) @(posedge aclk);
        rdc(`TMR_A_STATUS, 8'h48);
        rdr(`TMR_A_OC1L);
        rdc(`TMR_A_STATUS, 8'h08);
        rdr(`TMR_A_OC2L);
        rdc(`TMR_A_STATUS, 8'h00);
        wr(`TMR_A_CTRL2, 8'h06);
        capture_pin_2 <= 1'b1;
        repeat (8) @(posedge aclk);
        rdc(`TMR_A_STATUS, 8'h10);
        rdr(`TMR_A_IC2L);
        capture_pin_2 <= 1'b0;
        repeat (8) @(posedge aclk);
        rdc(`TMR_A_STATUS, 8'h00);
        capture_pin_1 <= 1'b0;
        repeat (8) @(posedge aclk);
        rdc(`TMR_A_STATUS, 8'h80);
        rdr(`TMR_A_IC1L);
        rdc(`TMR_A_STATUS, 8'h00);
        // pwm with period 0x20 and pulse 0x10 at /2: high about half of each period
        wr(`TMR_A_CTRL1, 8'h04);
        wr(`TMR_A_CTRL2, 8'hD4);
        wr(`TMR_A_CNTL, 8'h00);
        repeat (70) @(posedge aclk);
        repeat (132) begin
            @(posedge aclk);
            hi += compare_pin_1;
        end
        chk("pwm duty", {31'h0, hi >= 60 && hi <= 72}, 32'h1);
        chk("pin2 level", {31'h0, compare_pin_2}, 32'h1);
        rdc(`TMR_A_STATUS, 8'h80);
        // one pulse on a falling capture-1 edge, ended by the compare-1 match
        wr(`TMR_A_CTRL2, 8'hA4);
        wr(`TMR_A_CNTL, 8'h00);
        capture_pin_1 <= 1'b1;
        repeat (50) @(posedge aclk);
        chk("pulse idle", {31'h0, compare_pin_1}, 32'h0);
        capture_pin_1 <= 1'b0;
        repeat (8) @(posedge aclk);
        chk("pulse on", {31'h0, compare_pin_1}, 32'h1);
        repeat (40) @(posedge aclk);
        chk("pulse off", {31'h0, compare_pin_1}, 32'h0);
        wrap_up();
    end
endmodule // tmr_ctrl_tb
`default_nettype wire
